/* File: synth_select_pkg.sv */
// constants, field layouts and state codes of the paged port and synthesizer target select block
//
// Notes on behaviour
// [R1] full page byte picks the 128-byte window
// [R2] pages 0-6, 8, 10-13 valid; others reserved
// [R3] write trigger updates every masked synthesizer
// [R4] read trigger loads masked synthesizer into page
// [R5] host sets exactly one mask bit for reads
// [R6] bit0 general purpose, bits1-3 low jitter
// [R7] write trigger applies, then trigger reads zero
// [R8] read trigger loads, then trigger reads zero
// [R9] mask bits 15-10 read zero, writes ignored
package synth_select_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int PAGE_BYTES = 128;                 // bytes reached through one page
    localparam logic [6:0] WINDOW_CHOICE_LOW = 7'h7f; // page selector, seen on every page
    localparam logic [14:0] ADDR_WINDOW_CHOICE = 15'h067f; // home address of the page selector
    localparam logic [14:0] ADDR_MASK_HI = 15'h0682; // target mask, bits 15:8
    localparam logic [14:0] ADDR_MASK_LO = 15'h0683; // target mask, bits 7:0
    localparam logic [14:0] ADDR_TRIGGER = 15'h0684; // read and write trigger bits
    localparam logic [14:0] ADDR_STAGE0 = 15'h0685;  // first staged configuration byte
    localparam logic [14:0] ADDR_STAGE4 = 15'h0689;  // last staged configuration byte

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int MASK_W = 10;                      // live width of the target mask
    localparam int NUM_SYNTH = 4;                    // synthesizers that mask bits reach
    localparam int CFG_W = 40;                       // base frequency 16 bits, multiplier 24 bits
    localparam int TRIG_RD = 1;                      // read trigger bit
    localparam int TRIG_WR = 0;                      // write trigger bit
    localparam logic [7:0] PAGE_RST = 8'h00;         // page selector after reset
    localparam logic [9:0] MASK_RST = 10'h001;       // general purpose synthesizer selected
    localparam logic [1:0] TRIG_RST = 2'h0;          // no operation pending
    localparam logic [39:0] CFG_RST = 40'h1f40017bb0; // base 0x1f40, multiplier 0x017bb0

    // ----------------------------------------------------------------
    // serial frame states
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_CMD = 1'b0,                               // shifting the command byte
        ST_DATA = 1'b1                               // shifting the data byte
    } frame_state_t;

endpackage

/* File: paged_port_synth_target_select.sv */
// serial host port with page selector, synthesizer target mask and configuration transfer
module paged_port_synth_target_select (
    input wire logic clk,              // 100 MHz device clock
    input wire logic rst,              // synchronous reset, active high
    input wire logic sclk,             // serial clock from the host pin
    input wire logic cs_n,             // serial chip select, active low
    input wire logic mosi,             // serial data from the host
    output logic miso,                 // serial data to the host
    output logic miso_oe,              // high while miso is driven
    output logic [7:0] window_page,    // current page selector value
    output logic [9:0] target_mask,    // current synthesizer target mask
    output logic [159:0] synth_cfg     // applied configuration, synthesizer 0 in low bits
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sclk_s1;                             // first sync stage of sclk
        logic sclk_s2;                             // second sync stage of sclk
        logic sclk_s3;                             // delayed copy for edge detect
        logic cs_s1;                               // first sync stage of chip select
        logic cs_s2;                               // second sync stage of chip select
        logic mosi_s1;                             // first sync stage of mosi
        logic mosi_s2;                             // second sync stage of mosi
        synth_select_pkg::frame_state_t st;        // command or data byte
        logic [2:0] bit_cnt;                       // bits taken in this byte
        logic [7:0] sh;                            // receive shifter
        logic rd_cmd;                              // this frame reads
        logic [6:0] addr;                          // offset within page
        logic [7:0] tx;                            // transmit shifter
        logic [7:0] page;                          // page selector
        logic [9:0] mask;                          // target mask
        logic [1:0] trig;                          // read and write trigger bits
        logic [39:0] stage;                        // page copy of a configuration
        logic [3:0][39:0] cfg;                     // applied configuration per synthesizer
    } state_t;

    state_t q;                                     // registered state
    state_t d;                                     // next state

    logic sclk_rise;                               // synchronised rising edge
    logic sclk_fall;                               // synchronised falling edge
    logic [7:0] shift_next;                        // receive shifter with new bit
    logic byte_done;                               // eighth bit taken this cycle
    logic wr_evt;                                  // data byte written by host
    logic [14:0] wr_addr;                          // full address of a write
    logic [14:0] rd_addr;                          // full address of a read

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------

    // page codes that map onto real register pages
    function automatic logic page_ok(input logic [7:0] p);
        page_ok = (p <= 8'h06) || (p == 8'h08) || (p >= 8'h0a && p <= 8'h0d); // R2
    endfunction

    // byte k of the staged configuration, most significant first
    function automatic logic [7:0] stage_byte(input logic [39:0] s, input logic [14:0] a);
        logic [2:0] k;
        k = 3'(a - synth_select_pkg::ADDR_STAGE0);
        case (k)
            3'h0: stage_byte = s[39:32];
            3'h1: stage_byte = s[31:24];
            3'h2: stage_byte = s[23:16];
            3'h3: stage_byte = s[15:8];
            default: stage_byte = s[7:0];
        endcase
    endfunction

    // value returned for a read of a full address
    function automatic logic [7:0] rd_byte(input state_t s, input logic [14:0] a);
        if (a[6:0] == synth_select_pkg::WINDOW_CHOICE_LOW)
            rd_byte = s.page;                                   // R1
        else if (!page_ok(a[14:7]))
            rd_byte = 8'h00;                                    // R2
        else if (a == synth_select_pkg::ADDR_MASK_HI)
            rd_byte = {6'h00, s.mask[9:8]};                     // R9
        else if (a == synth_select_pkg::ADDR_MASK_LO)
            rd_byte = s.mask[7:0];
        else if (a == synth_select_pkg::ADDR_TRIGGER)
            rd_byte = {6'h00, s.trig};                          // R7 R8
        else if (a >= synth_select_pkg::ADDR_STAGE0 && a <= synth_select_pkg::ADDR_STAGE4)
            rd_byte = stage_byte(s.stage, a);
        else
            rd_byte = 8'h00;
    endfunction

    // ----------------------------------------------------------------
    // edge detect and address forming
    // ----------------------------------------------------------------
    assign sclk_rise = q.sclk_s2 & ~q.sclk_s3;
    assign sclk_fall = ~q.sclk_s2 & q.sclk_s3;
    assign shift_next = {q.sh[6:0], q.mosi_s2};
    assign byte_done = ~q.cs_s2 & sclk_rise & (q.bit_cnt == 3'h7);
    assign wr_evt = byte_done & (q.st == synth_select_pkg::ST_DATA) & ~q.rd_cmd;
    assign wr_addr = {q.page, q.addr};                            // R1
    assign rd_addr = {q.page, shift_next[6:0]};

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------

    // synchronisers, serial shifting, register writes and the transfer engine
    always_comb
    begin
        d = q;
        d.sclk_s1 = sclk;
        d.sclk_s2 = q.sclk_s1;
        d.sclk_s3 = q.sclk_s2;
        d.cs_s1 = cs_n;
        d.cs_s2 = q.cs_s1;
        d.mosi_s1 = mosi;
        d.mosi_s2 = q.mosi_s1;

        // pending trigger acts one cycle after it was written, then clears
        if (q.trig[synth_select_pkg::TRIG_RD])
        begin
            // lowest masked synthesizer wins if the host sets several
            for (int i = synth_select_pkg::NUM_SYNTH - 1; i >= 0; i--)
            begin
                if (q.mask[i])
                    d.stage = q.cfg[i];                         // R4 R6
            end
            d.trig = 2'h0;                                      // R8
        end
        else if (q.trig[synth_select_pkg::TRIG_WR])
        begin
            // mask bits 4 to 9 reach no synthesizer
            for (int i = 0; i < synth_select_pkg::NUM_SYNTH; i++)
            begin
                if (q.mask[i])
                    d.cfg[i] = q.stage;                         // R3 R6
            end
            d.trig = 2'h0;                                      // R7
        end

        if (q.cs_s2)
        begin
            // deselected: frame restarts at a command byte
            d.st = synth_select_pkg::ST_CMD;
            d.bit_cnt = 3'h0;
        end
        else if (sclk_rise)
        begin
            // take one bit, msb first
            d.sh = shift_next;
            d.bit_cnt = q.bit_cnt + 3'h1;
            if (q.bit_cnt == 3'h7)
            begin
                case (q.st)
                    synth_select_pkg::ST_CMD:
                    begin
                        // command: bit 7 read, bits 6:0 offset in page
                        d.rd_cmd = shift_next[7];
                        d.addr = shift_next[6:0];
                        d.tx = rd_byte(q, rd_addr);
                        d.st = synth_select_pkg::ST_DATA;
                    end
                    synth_select_pkg::ST_DATA:
                    begin
                        if (!q.rd_cmd)
                        begin
                            if (q.addr == synth_select_pkg::WINDOW_CHOICE_LOW)
                                d.page = shift_next;             // R1
                            else if (!page_ok(q.page))
                                d.page = q.page;                 // R2
                            else if (wr_addr == synth_select_pkg::ADDR_MASK_HI)
                                d.mask[9:8] = shift_next[1:0];   // R9
                            else if (wr_addr == synth_select_pkg::ADDR_MASK_LO)
                                d.mask[7:0] = shift_next;
                            else if (wr_addr == synth_select_pkg::ADDR_TRIGGER)
                                d.trig = shift_next[1:0];        // a new trigger wins over the clear
                            else if (wr_addr >= synth_select_pkg::ADDR_STAGE0 &&
                                     wr_addr <= synth_select_pkg::ADDR_STAGE4)
                            begin
                                case (3'(wr_addr - synth_select_pkg::ADDR_STAGE0))
                                    3'h0: d.stage[39:32] = shift_next;
                                    3'h1: d.stage[31:24] = shift_next;
                                    3'h2: d.stage[23:16] = shift_next;
                                    3'h3: d.stage[15:8] = shift_next;
                                    default: d.stage[7:0] = shift_next;
                                endcase
                            end
                        end
                        d.st = synth_select_pkg::ST_CMD;
                    end
                    default: d.st = synth_select_pkg::ST_CMD;
                endcase
            end
        end
        else if (sclk_fall && q.st == synth_select_pkg::ST_DATA && q.bit_cnt != 3'h0)
        begin
            // present the next read bit on the falling edge; the fall right after
            // the command byte keeps data bit 7 on the line for the first rise
            d.tx = {q.tx[6:0], 1'b0};
        end

        if (rst)
        begin
            d = '0;
            d.sclk_s1 = 1'b0;
            d.cs_s1 = 1'b1;
            d.cs_s2 = 1'b1;
            d.st = synth_select_pkg::ST_CMD;
            d.page = synth_select_pkg::PAGE_RST;
            d.mask = synth_select_pkg::MASK_RST;
            d.trig = synth_select_pkg::TRIG_RST;
            d.stage = synth_select_pkg::CFG_RST;
            d.cfg = {synth_select_pkg::NUM_SYNTH{synth_select_pkg::CFG_RST}};
        end
    end

    // one register for the whole state
    always_ff @(posedge clk)
    begin
        q <= d;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign miso = q.tx[7];
    assign miso_oe = ~q.cs_s2 & (q.st == synth_select_pkg::ST_DATA) & q.rd_cmd;
    assign window_page = q.page;
    assign target_mask = q.mask;
    assign synth_cfg = q.cfg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_page_write_full: assert property ( // R1
        (wr_evt && q.addr == synth_select_pkg::WINDOW_CHOICE_LOW) |=> q.page == $past(shift_next))
        else $error("page selector did not take the written byte");

    a_reserved_page_blocks: assert property ( // R2
        (wr_evt && !page_ok(q.page) && q.addr != synth_select_pkg::WINDOW_CHOICE_LOW)
        |=> $stable(q.mask) && $stable(q.stage))
        else $error("write on a reserved page changed a register");

    a_write_hits_masked: assert property ( // R3
        (q.trig == 2'h1 && q.mask[1]) |=> q.cfg[1] == $past(q.stage))
        else $error("masked synthesizer not updated by write trigger");

    a_write_skips_unmasked: assert property ( // R3
        (q.trig == 2'h1 && !q.mask[2]) |=> $stable(q.cfg[2]))
        else $error("unmasked synthesizer changed by write trigger");

    a_read_loads_stage: assert property ( // R4
        (q.trig[1] && q.mask[3:0] == 4'h2) |=> q.stage == $past(q.cfg[1]))
        else $error("read trigger did not load the masked synthesizer");

    a_gp_bit_zero: assert property ( // R6
        (q.trig == 2'h1 && q.mask[0]) |=> q.cfg[0] == $past(q.stage))
        else $error("mask bit 0 did not reach the general purpose synthesizer");

    a_upper_mask_none: assert property ( // R6
        (q.trig == 2'h1 && q.mask[3:0] == 4'h0) |=> $stable(q.cfg))
        else $error("mask bits 4 to 9 changed a synthesizer");

    a_trigger_self_clear: assert property ( // R7
        (q.trig != 2'h0 && !wr_evt) |=> q.trig == 2'h0)
        else $error("trigger did not clear after the operation");

    a_read_trigger_done: assert property ( // R8
        $rose(q.trig[1]) |-> ##[1:2] q.trig == 2'h0)
        else $error("read trigger still pending");

    a_mask_upper_zero: assert property ( // R9
        (byte_done && q.st == synth_select_pkg::ST_CMD && shift_next[7]
         && rd_addr == synth_select_pkg::ADDR_MASK_HI) |=> q.tx[7:2] == 6'h00)
        else $error("reserved mask bits read back non-zero");

    c_write_trigger: cover property (q.trig == 2'h1 ##1 q.trig == 2'h0);
    c_read_trigger: cover property (q.trig == 2'h2 ##1 q.trig == 2'h0);
    c_page_change: cover property (wr_evt && q.addr == synth_select_pkg::WINDOW_CHOICE_LOW);

endmodule

/* File: spi_host_model.sv */
// host controller model that runs mode 0 serial frames against the block
module spi_host_model (
    input wire logic clk,     // device clock, paces the serial edges
    output logic sclk,        // serial clock, still low outside frames
    output logic cs_n,        // chip select, active low
    output logic mosi,        // serial data to the device
    input wire logic miso,    // serial data from the device
    input wire logic miso_oe  // high while the device drives miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int HALF = 6;  // clk cycles per sclk level, above the three the synchronisers need

    // idle levels before the first frame
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end

    // one sclk level, every change lands on a falling clk edge
    task automatic half_wait;
        repeat (HALF) @(negedge clk);
    endtask

    // ----------------------------------------------------------------
    // one frame: command byte then data byte, msb first
    // ----------------------------------------------------------------
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {cmd, wd};
        rd = 8'h00;
        @(negedge clk);
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            mosi = sh[i];
            half_wait();
            // sample at the rise; a released line reads as the inverse so it cannot pass
            if (i < 8)
            begin
                rd[i] = miso_oe ? miso : ~miso;
            end
            sclk = 1'b1;
            half_wait();
            sclk = 1'b0;
        end
        half_wait();
        cs_n = 1'b1;
        mosi = ~mosi;  // released data line does not keep its last value
        half_wait();
    endtask
endmodule

/* File: paged_port_synth_target_select_bench.sv */
// self-checking bench for the paged port and synthesizer target select block
module paged_port_synth_target_select_bench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // signals and instances
    // ----------------------------------------------------------------
    logic clk = 1'b0;        // 100 MHz device clock
    logic rst = 1'b1;        // synchronous reset
    logic sclk, cs_n, mosi;  // serial lines from the host model
    logic miso, miso_oe;     // serial answer from the device
    logic [7:0] window_page; // page selector output
    logic [9:0] target_mask; // target mask output
    logic [159:0] cfg;       // applied configurations
    int mismatches = 0;      // failed comparisons
    int checks = 0;          // comparisons made
    logic [7:0] pages [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08,
                               8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h07, 8'h09, 8'h0e};
    logic [7:0] stage [5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9a}; // staged bytes, msb first

    always #5 clk = ~clk;

    paged_port_synth_target_select DUT (.clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .window_page(window_page), .target_mask(target_mask), .synth_cfg(cfg));
    spi_host_model HOST (.clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

    // ----------------------------------------------------------------
    // compare, access and closing tasks
    // ----------------------------------------------------------------
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_word(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // write one byte at an offset of the current page
    task automatic wr(input logic [6:0] off, input logic [7:0] d);
        logic [7:0] unused;
        HOST.xfer({1'b0, off}, d, unused);
    endtask

    // read one byte at an offset of the current page and compare it
    task automatic rd(input logic [6:0] off, input logic [7:0] exp, input string what);
        logic [7:0] v;
        HOST.xfer({1'b1, off}, 8'h00, v);
        chk_byte(what, exp, v);
    endtask

    // check all four applied configurations
    task automatic chk_cfg(input logic [39:0] e0, e1, e2, e3);
        chk_word("cfg0", e0, cfg[39:0]);
        chk_word("cfg1", e1, cfg[79:40]);
        chk_word("cfg2", e2, cfg[119:80]);
        chk_word("cfg3", e3, cfg[159:120]);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // watchdog, the full sequence needs about 21k clk cycles
    initial
    begin
        #600us;
        mismatches++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [39:0] st;
        st = 40'h123456789a;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        chk_byte("page reset", 8'h00, window_page);
        chk_word("mask reset", 40'h1, {30'h0, target_mask});
        chk_cfg(synth_select_pkg::CFG_RST, synth_select_pkg::CFG_RST, synth_select_pkg::CFG_RST,
                synth_select_pkg::CFG_RST);
        rd(7'h7f, 8'h00, "page read");
        // every valid code and reserved codes 7, 9 and 14; mask writes off page 13 go nowhere
        foreach (pages[i])
        begin
            wr(7'h7f, pages[i]);
            chk_byte("page out", pages[i], window_page);
            rd(7'h7f, pages[i], "page back");
            if (pages[i] != 8'h0d)
            begin
                wr(7'h03, 8'hff);
                rd(7'h03, 8'h00, "off page");
            end
        end
        chk_word("mask kept", 40'h1, {30'h0, target_mask});
        // page 13: reserved mask bits, then a write to synthesizers 1 and 3
        wr(7'h7f, 8'h0d);
        wr(7'h02, 8'hff);
        rd(7'h02, 8'h03, "mask hi");
        wr(7'h03, 8'hfa);
        chk_word("mask out", 40'h3fa, {30'h0, target_mask});
        foreach (stage[i])
            wr(7'(5 + i), stage[i]);
        wr(7'h04, 8'h01);
        rd(7'h04, 8'h00, "wr done");
        chk_cfg(synth_select_pkg::CFG_RST, st, synth_select_pkg::CFG_RST, st);
        // only the unused mask bits: nothing may change
        wr(7'h03, 8'hf0);
        wr(7'h05, 8'hee);
        wr(7'h04, 8'h01);
        rd(7'h04, 8'h00, "wr none");
        chk_cfg(synth_select_pkg::CFG_RST, st, synth_select_pkg::CFG_RST, st);
        // readback of synthesizer 1 with exactly one mask bit set
        wr(7'h02, 8'h00);
        wr(7'h03, 8'h02);
        foreach (stage[i])
            wr(7'(5 + i), 8'h00);
        wr(7'h04, 8'h02);
        rd(7'h04, 8'h00, "rd done");
        foreach (stage[i])
            rd(7'(5 + i), stage[i], "readback one");
        // readback of the general purpose synthesizer
        wr(7'h03, 8'h01);
        wr(7'h04, 8'h02);
        rd(7'h04, 8'h00, "rd done");
        for (int i = 0; i < 5; i++)
            rd(7'(5 + i), synth_select_pkg::CFG_RST[39 - 8 * i -: 8], "readback zero");
        // write through the general purpose synthesizer alone
        foreach (stage[i])
            wr(7'(5 + i), stage[i]);
        wr(7'h04, 8'h01);
        rd(7'h04, 8'h00, "wr gp");
        chk_cfg(st, st, synth_select_pkg::CFG_RST, st);
        end_sim();
    end
endmodule
